// ---- hw/lcri_map.vh ----
// constants for the lcd controller reset and initialization block
`ifndef LCRI_MAP_VH
`define LCRI_MAP_VH
// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define LCRI_CLK_MHZ          100
`define LCRI_BUSY_TIME_US     2000
`define LCRI_BUSY_CYC         (`LCRI_BUSY_TIME_US * `LCRI_CLK_MHZ)
`define LCRI_CLEAR_OSC        165
`define LCRI_RESET_MIN_OSC    3
`define LCRI_FRAME_DIV        3072
// --------------------------------------------------------------
// reset values of the instruction state
// --------------------------------------------------------------
`define LCRI_RST_INC_DIR      1'b1
`define LCRI_RST_SHIFT        1'b0
`define LCRI_RST_DISP_ON      1'b0
`define LCRI_RST_CURSOR_ON    1'b0
`define LCRI_RST_CURSOR_BLINK 1'b0
`define LCRI_RST_BUS_WIDTH    1'b1
`define LCRI_RST_TWO_LINE     1'b0
`define LCRI_RST_MUX_RATIO    1'b0
`define LCRI_RST_EXT_PAGE     1'b0
`define LCRI_RST_ICON_ONLY    1'b0
`define LCRI_RST_ICON_BLINK   1'b0
`define LCRI_RST_LAYOUT       1'b0
`define LCRI_RST_ORIENT       2'h0
`define LCRI_RST_TEMPCO       1'b0
`define LCRI_RST_VOLT         6'h00
`define LCRI_RST_PUMP_HI      1'b1
`define LCRI_RST_PUMP_LO      1'b0
`define LCRI_RST_ADDR         7'h00
// --------------------------------------------------------------
// field positions on the host data lines
// --------------------------------------------------------------
`define LCRI_BUSY_BIT         7
`define LCRI_SA_BIT           3
`endif

// ---- hw/lcri_reset_init.v ----
// reset, clocking and initialization sequencer of a character lcd controller
`timescale 1ns/10ps
`include "lcri_map.vh"

module lcri_reset_init (
    input  wire       clk,               // system clock, 100 mhz
    input  wire       rst,               // system reset, async high
    input  wire       ext_reset,         // external reset pin, active high
    input  wire       osc_pin,           // oscillator pin level
    input  wire       powerdown_select,  // power-down select pin
    input  wire       strobe,            // parallel bus strobe
    input  wire       rw_dir,            // 1 = read, 0 = write
    input  wire       reg_select,        // register select pin
    input  wire [7:0] data_in,           // data lines as driven by host
    output reg  [7:0] data_out,          // data lines driven by device
    output reg  [7:0] data_oe,           // per-line output enable
    output reg        busy_indication,   // busy state
    output reg        data3_addr_select, // sampled serial address bit
    output reg        use_int_osc,       // internal oscillator selected
    output reg        osc_run,           // oscillator running
    output reg        core_tick,         // one-cycle core clock enable
    output reg        frame_tick,        // one-cycle frame pulse
    output reg        outputs_grounded,  // display outputs tied low
    output reg        serial_idle,       // serial interface at idle
    output reg        inc_dir,           // entry mode direction
    output reg        disp_shift,        // entry mode shift
    output reg        disp_on,           // display on
    output reg        cursor_on,         // cursor on
    output reg        cursor_blink,      // cursor blink
    output reg        bus_width_sel,     // 1 = 8-bit bus
    output reg        two_line,          // line count
    output reg        mux_ratio_sel,     // 0 = 1:18
    output reg        ext_page,          // instruction page
    output reg        icon_only,         // icon mode
    output reg        icon_blink,        // icon blink
    output reg        layout_sel,        // screen layout
    output reg  [1:0] orient_sel,        // display orientation
    output reg        tempco_sel_a,      // temperature coefficient a
    output reg        tempco_sel_b,      // temperature coefficient b
    output reg  [5:0] drive_volt_char,   // character mode drive voltage
    output reg  [5:0] drive_volt_icon,   // icon mode drive voltage
    output reg        pump_stage_hi,     // pump stage select high
    output reg        pump_stage_lo,     // pump stage select low
    output reg  [6:0] ddram_addr,        // address pointer
    output reg        clearing           // clear display in progress
);

    // --------------------------------------------------------------
    // parameters and local state
    // --------------------------------------------------------------
    parameter BUSY_CYC = `LCRI_BUSY_CYC;       // shorten for simulation
    parameter OSC_DIV  = 16'd1;                 // clk cycles per core tick, slower via divider

    // sequencer states, one-hot so each state is a single flop to decode;
    // the clear state is entered straight from system reset, so a power-up
    // runs the same clear and busy window as a reset pin pulse would
    // the reset state is held for as long as the pin stays high, and the
    // defaults are reloaded on every cycle of it
    localparam [3:0] ST_IDLE  = 4'b0001;        // normal operation
    localparam [3:0] ST_RESET = 4'b0010;        // external reset held
    localparam [3:0] ST_CLEAR = 4'b0100;        // clear display running
    localparam [3:0] ST_WAIT  = 4'b1000;        // remainder of busy time

    // counters are sized for the real busy time at the full clock rate;
    // the busy counter is wide so a long power-down cannot wrap it early
    reg  [3:0]  state_q;                        // sequencer state
    reg  [15:0] div_q;                          // core tick divider
    reg  [11:0] frame_q;                        // frame divider count
    reg  [1:0]  rst_cnt_q;                      // reset hold count in core ticks
    reg  [7:0]  clr_cnt_q;                      // clear display count
    reg  [31:0] busy_cnt_q;                     // busy time count
    wire        clock_ok;                       // a core clock is present
    wire        tick;                           // core tick this cycle

    // the core clock is modelled as an enable pulse, never as a second clock;
    // a stopped clock simply means no more enable pulses, so every counter
    // that waits on core ticks freezes in place and resumes later
    // limitation: an external clock is taken as always running
    // internal oscillator dies in power-down, an external clock keeps running
    assign clock_ok = ~(powerdown_select & osc_pin);
    assign tick     = clock_ok && (div_q == OSC_DIV - 16'd1);

    // --------------------------------------------------------------
    // core clock enable and frame timing
    // --------------------------------------------------------------
    // the divider counts every clock while the core clock runs, the frame count only core ticks; bus pins never reach here
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q      <= 16'h0000;
            frame_q    <= 12'h000;
            core_tick  <= 1'b0;
            frame_tick <= 1'b0;
        end else begin
            core_tick  <= tick;
            frame_tick <= 1'b0;
            if (!clock_ok) begin
                div_q <= 16'h0000;               // frozen clock, frozen frame
            end else if (tick) begin
                div_q <= 16'h0000;
                if (frame_q == `LCRI_FRAME_DIV - 1) begin
                    frame_q    <= 12'h000;
                    frame_tick <= 1'b1;
                end else begin
                    frame_q <= frame_q + 12'h001;
                end
            end else begin
                div_q <= div_q + 16'h0001;
            end
        end
    end

    // --------------------------------------------------------------
    // clock source and power-down status
    // --------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            use_int_osc      <= 1'b1;
            osc_run          <= 1'b0;
            outputs_grounded <= 1'b1;
        end else begin
            use_int_osc      <= osc_pin;
            osc_run          <= clock_ok;
            outputs_grounded <= powerdown_select;
        end
    end

    // --------------------------------------------------------------
    // reset and initialization sequencer
    // --------------------------------------------------------------
    // the pin counter clears on any low sample, so glitches never add up;
    // once accepted, the acceptance repeats on every tick while the pin
    // stays high, restarting the busy count from the last held tick
    // busy time is counted in system clocks, the clear in core ticks,
    // so a slow external clock stretches the clear but not the busy window
    // trade-off: the busy count may run out before a very slow clear; the state machine
    // still waits for the clear to finish before it drops busy
    // ext reset takes effect only after three held core ticks
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q         <= ST_CLEAR;
            rst_cnt_q       <= 2'h0;
            clr_cnt_q       <= 8'h00;
            busy_cnt_q      <= 32'h0;
            busy_indication <= 1'b1;
            clearing        <= 1'b1;
            serial_idle     <= 1'b1;
        end else begin
            if (!ext_reset) begin
                rst_cnt_q <= 2'h0;
            end else if (tick && rst_cnt_q != `LCRI_RESET_MIN_OSC - 1) begin
                rst_cnt_q <= rst_cnt_q + 2'h1;
            end
            if (ext_reset && tick && rst_cnt_q == `LCRI_RESET_MIN_OSC - 1) begin
                state_q         <= ST_RESET;
                busy_indication <= 1'b1;
                clearing        <= 1'b0;
                serial_idle     <= 1'b1;
                clr_cnt_q       <= 8'h00;
                busy_cnt_q      <= 32'h0;
            end else begin
                if (busy_indication) begin
                    busy_cnt_q <= busy_cnt_q + 32'h1;
                end
                case (state_q)
                    ST_RESET: begin
                        if (!ext_reset) begin
                            state_q  <= ST_CLEAR;
                            clearing <= 1'b1;
                        end
                    end
                    ST_CLEAR: begin
                        if (tick) begin
                            if (clr_cnt_q == `LCRI_CLEAR_OSC - 1) begin
                                state_q  <= ST_WAIT;
                                clearing <= 1'b0;
                            end else begin
                                clr_cnt_q <= clr_cnt_q + 8'h01;
                            end
                        end
                    end
                    ST_WAIT: begin
                        if (busy_cnt_q >= BUSY_CYC - 1) begin
                            state_q         <= ST_IDLE;
                            busy_indication <= 1'b0;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // --------------------------------------------------------------
    // default instruction state, loaded while the reset is held
    // nothing else writes these yet: the instruction decoder lives outside
    // this block and takes over the settings once busy has cleared
    // values come from the constants header; the bench repeats them in its own DEF
    // --------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            inc_dir         <= `LCRI_RST_INC_DIR;
            disp_shift      <= `LCRI_RST_SHIFT;
            disp_on         <= `LCRI_RST_DISP_ON;
            cursor_on       <= `LCRI_RST_CURSOR_ON;
            cursor_blink    <= `LCRI_RST_CURSOR_BLINK;
            bus_width_sel   <= `LCRI_RST_BUS_WIDTH;
            two_line        <= `LCRI_RST_TWO_LINE;
            mux_ratio_sel   <= `LCRI_RST_MUX_RATIO;
            ext_page        <= `LCRI_RST_EXT_PAGE;
            icon_only       <= `LCRI_RST_ICON_ONLY;
            icon_blink      <= `LCRI_RST_ICON_BLINK;
            layout_sel      <= `LCRI_RST_LAYOUT;
            orient_sel      <= `LCRI_RST_ORIENT;
            tempco_sel_a    <= `LCRI_RST_TEMPCO;
            tempco_sel_b    <= `LCRI_RST_TEMPCO;
            drive_volt_char <= `LCRI_RST_VOLT;
            drive_volt_icon <= `LCRI_RST_VOLT;
            pump_stage_hi   <= `LCRI_RST_PUMP_HI;
            pump_stage_lo   <= `LCRI_RST_PUMP_LO;
            ddram_addr      <= `LCRI_RST_ADDR;
        end else if (state_q == ST_RESET) begin
            inc_dir         <= `LCRI_RST_INC_DIR;
            disp_shift      <= `LCRI_RST_SHIFT;
            disp_on         <= `LCRI_RST_DISP_ON;
            cursor_on       <= `LCRI_RST_CURSOR_ON;
            cursor_blink    <= `LCRI_RST_CURSOR_BLINK;
            bus_width_sel   <= `LCRI_RST_BUS_WIDTH;
            two_line        <= `LCRI_RST_TWO_LINE;
            mux_ratio_sel   <= `LCRI_RST_MUX_RATIO;
            ext_page        <= `LCRI_RST_EXT_PAGE;
            icon_only       <= `LCRI_RST_ICON_ONLY;
            icon_blink      <= `LCRI_RST_ICON_BLINK;
            layout_sel      <= `LCRI_RST_LAYOUT;
            orient_sel      <= `LCRI_RST_ORIENT;
            tempco_sel_a    <= `LCRI_RST_TEMPCO;
            tempco_sel_b    <= `LCRI_RST_TEMPCO;
            drive_volt_char <= `LCRI_RST_VOLT;
            drive_volt_icon <= `LCRI_RST_VOLT;
            pump_stage_hi   <= `LCRI_RST_PUMP_HI;
            pump_stage_lo   <= `LCRI_RST_PUMP_LO;
            ddram_addr      <= `LCRI_RST_ADDR;
        end
    end

    // --------------------------------------------------------------
    // host data pins
    // --------------------------------------------------------------
    // the enable is registered, so the lines turn on one cycle after the
    // request and stay on one cycle after it ends; the host must not drive
    // the lines in that trailing cycle or the two sides fight
    // the address select bit is sampled on every cycle, as the pin
    // level is static while the serial bus is in use
    // only a read with strobe high and instruction register gets busy out;
    // in 4-bit mode the low lines are never driven, the host leaves them open
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            data_out          <= 8'h00;
            data_oe           <= 8'h00;
            data3_addr_select <= 1'b0;
        end else begin
            data3_addr_select <= data_in[`LCRI_SA_BIT];
            data_out          <= {busy_indication, ddram_addr};
            if (strobe && rw_dir && !reg_select) begin
                data_oe <= bus_width_sel ? 8'hff : 8'hf0;
            end else begin
                data_oe <= 8'h00;
            end
        end
    end

endmodule // lcri_reset_init

// ---- testbench/lcri_reset_init_assertions.sv ----
// pin-level checks for the lcd reset and initialization block
`timescale 1ns/10ps
module lcri_reset_init_assertions #(
    parameter BUSY_CYC = 400,
    parameter OSC_DIV  = 16'd1
) (
    input wire       clk,
    input wire       rst,
    input wire       ext_reset,
    input wire       osc_pin,
    input wire       powerdown_select,
    input wire       strobe,
    input wire       rw_dir,
    input wire       reg_select,
    input wire [7:0] data_out,
    input wire [7:0] data_oe,
    input wire       busy_indication,
    input wire       use_int_osc,
    input wire       core_tick,
    input wire       frame_tick,
    input wire       outputs_grounded,
    input wire       clearing,
    input wire       inc_dir,
    input wire       pump_stage_hi,
    input wire       pump_stage_lo
);
    // ----------------------------------------------------------
    // helper counters
    // ----------------------------------------------------------
    reg  [12:0] tick_q; // core ticks since the last frame pulse
    reg         seen_q; // first frame pulse seen, so the count is whole
    reg  [8:0]  clr_q;  // ticks spent clearing
    reg  [19:0] up_q;   // cycles since system reset
    reg  [19:0] ext_q;  // cycles since the reset pin was last high
    wire        rd = strobe && rw_dir && !reg_select; // status read request
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_q <= 13'h0000;
            seen_q <= 1'b0;
            clr_q  <= 9'h000;
            up_q   <= 20'h00000;
            ext_q  <= 20'h00000;
        end else begin
            tick_q <= frame_tick ? 13'h0000 : tick_q + {12'h000, core_tick};
            seen_q <= seen_q | frame_tick;
            clr_q  <= clearing ? clr_q + {8'h00, core_tick} : 9'h000;
            // saturate so long runs never wrap back into the busy window
            up_q   <= (up_q == 20'hfffff) ? up_q : up_q + 20'h00001;
            ext_q  <= ext_reset ? 20'h00000 : ((ext_q == 20'hfffff) ? ext_q : ext_q + 20'h00001);
        end
    end
    a_read_answer: assert property (@(posedge clk) disable iff (rst)
        rd ##1 $stable(busy_indication) |-> data_oe[7:4] == 4'hf && data_out[7] == busy_indication)
        else $error("status read did not show busy on the top line");
    a_read_release: assert property (@(posedge clk) disable iff (rst)
        !rd [*2] |=> data_oe == 8'h00) else $error("data lines driven without a read");
    a_upper_lines: assert property (@(posedge clk) disable iff (rst)
        data_oe[3:0] != 4'h0 |-> data_oe[7:4] == 4'hf) else $error("lower lines without upper");
    a_osc_select: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && $stable(osc_pin) |-> use_int_osc == osc_pin) else $error("clock source");
    a_frame_div: assert property (@(posedge clk) disable iff (rst)
        frame_tick && seen_q |-> tick_q + core_tick == 13'h0c00) else $error("frame period");
    a_clear_len: assert property (@(posedge clk) disable iff (rst)
        $fell(clearing) |-> clr_q >= 9'h0a4 && clr_q <= 9'h0a6) else $error("clear length");
    a_busy_hold: assert property (@(posedge clk) disable iff (rst)
        up_q < BUSY_CYC - 2 || clearing |-> busy_indication) else $error("busy dropped early");
    a_busy_done: assert property (@(posedge clk) disable iff (rst)
        ext_q > BUSY_CYC + 2 && up_q > BUSY_CYC + 2 |-> !busy_indication) else $error("busy stuck");
    a_pd_stop: assert property (@(posedge clk) disable iff (rst)
        (powerdown_select && osc_pin) [*2] |-> !core_tick && outputs_grounded)
        else $error("power-down did not stop the clock");
    a_pd_ext_clk: assert property (@(posedge clk) disable iff (rst)
        (powerdown_select && !osc_pin) [*2] |-> core_tick && outputs_grounded)
        else $error("external clock halted in power-down");
    a_post_state: assert property (@(posedge clk) disable iff (rst)
        !clearing |-> inc_dir && pump_stage_hi && !pump_stage_lo) else $error("settings lost");
endmodule // lcri_reset_init_assertions

bind lcri_reset_init lcri_reset_init_assertions #(.BUSY_CYC(BUSY_CYC), .OSC_DIV(OSC_DIV)) u_chk (
    .clk(clk), .rst(rst), .ext_reset(ext_reset), .osc_pin(osc_pin),
    .powerdown_select(powerdown_select), .strobe(strobe), .rw_dir(rw_dir),
    .reg_select(reg_select), .data_out(data_out), .data_oe(data_oe),
    .busy_indication(busy_indication), .use_int_osc(use_int_osc), .core_tick(core_tick),
    .frame_tick(frame_tick), .outputs_grounded(outputs_grounded), .clearing(clearing),
    .inc_dir(inc_dir), .pump_stage_hi(pump_stage_hi), .pump_stage_lo(pump_stage_lo));

// ---- testbench/lcri_host_model.sv ----
// behavioural host microcontroller on the parallel side of the lcd block
`timescale 1ns/10ps
module lcri_host_model (
    input  wire       clk,
    input  wire [7:0] data_out,
    input  wire [7:0] data_oe,
    output reg        strobe,
    output reg        rw_dir,
    output reg        reg_select,
    output reg        ext_reset,
    output reg  [7:0] data_in
);
    reg     [7:0] drv_q; // value the host puts on the lines
    reg           own_q; // host drives the lines
    integer       i;     // line index
    // ----------------------------------------------------------
    // line resolution: pull-ups make a released line read high
    // ----------------------------------------------------------
    always @* begin
        for (i = 0; i < 8; i = i + 1) begin
            data_in[i] = data_oe[i] ? data_out[i] : (own_q ? drv_q[i] : 1'b1);
        end
    end
    initial begin
        strobe     = 1'b0;
        rw_dir     = 1'b1;
        reg_select = 1'b1;
        ext_reset  = 1'b0;
        drv_q      = 8'h00;
        own_q      = 1'b0;
    end
    // status read: answer taken the cycle after the request edge
    task status_read(output logic [7:0] val, output logic [7:0] oe);
        begin
            @(posedge clk);
            strobe     <= 1'b1;
            rw_dir     <= 1'b1;
            reg_select <= 1'b0;
            @(posedge clk);
            @(negedge clk);
            val = data_in;
            oe  = data_oe;
            @(posedge clk);
            strobe     <= 1'b0;
            reg_select <= 1'b1;
        end
    endtask
    // write: lines stay driven until idle() so the caller can look
    task write_cycle(input logic [7:0] d);
        begin
            @(posedge clk);
            strobe <= 1'b1;
            rw_dir <= 1'b0;
            drv_q  <= d;
            own_q  <= 1'b1;
            @(posedge clk);
            @(negedge clk);
        end
    endtask
    task idle;
        begin
            @(posedge clk);
            strobe <= 1'b0;
            rw_dir <= 1'b1;
            own_q  <= 1'b0;
        end
    endtask
    // reset pin pulse of n clock edges
    task ext_pulse(input int n);
        begin
            @(posedge clk);
            ext_reset <= 1'b1;
            repeat (n) @(posedge clk);
            ext_reset <= 1'b0;
        end
    endtask
endmodule // lcri_host_model

// ---- testbench/lcri_reset_init_tb.sv ----
// self-checking bench for the lcd reset and initialization block
`timescale 1ns/10ps
module lcri_reset_init_tb;
    localparam int BUSY = 400; // shortened busy time
    localparam logic [36:0] DEF = {1'b1, 4'h0, 1'b1, 22'h0, 1'b1, 8'h00}; // reset state
    reg         clk, rst, osc_pin, powerdown_select; // bench-driven pins
    wire        strobe, rw_dir, reg_select, ext_reset;  // host-driven pins
    wire [7:0]  data_in, data_out, data_oe;             // data lines
    wire        busy, d3, use_int, osc_run, tick, frame, gnd, sidle, clearing;
    wire [36:0] st;                                     // settings, packed
    logic [7:0] v, oe;                                  // read results
    int         n_checks, n_mismatch, cyc, rel, n, r;   // counters
    logic [5:0] rows [4] = '{6'h39, 6'h17, 6'h06, 6'h2e}; // osc,pd -> int,run,tick,gnd
    lcri_reset_init #(.BUSY_CYC(BUSY), .OSC_DIV(16'd1)) u_lcri_reset_init (
        .clk(clk), .rst(rst), .ext_reset(ext_reset), .osc_pin(osc_pin),
        .powerdown_select(powerdown_select), .strobe(strobe), .rw_dir(rw_dir),
        .reg_select(reg_select), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .busy_indication(busy), .data3_addr_select(d3), .use_int_osc(use_int),
        .osc_run(osc_run), .core_tick(tick), .frame_tick(frame), .outputs_grounded(gnd),
        .serial_idle(sidle), .inc_dir(st[36]), .disp_shift(st[35]), .disp_on(st[34]),
        .cursor_on(st[33]), .cursor_blink(st[32]), .bus_width_sel(st[31]), .two_line(st[30]),
        .mux_ratio_sel(st[29]), .ext_page(st[28]), .icon_only(st[27]), .icon_blink(st[26]),
        .layout_sel(st[25]), .orient_sel(st[24:23]), .tempco_sel_a(st[22]),
        .tempco_sel_b(st[21]), .drive_volt_char(st[20:15]), .drive_volt_icon(st[14:9]),
        .pump_stage_hi(st[8]), .pump_stage_lo(st[7]), .ddram_addr(st[6:0]),
        .clearing(clearing));
    lcri_host_model u_lcri_host_model (.clk(clk), .data_out(data_out), .data_oe(data_oe),
        .strobe(strobe), .rw_dir(rw_dir), .reg_select(reg_select), .ext_reset(ext_reset),
        .data_in(data_in));
    // ----------------------------------------------------------
    // clock, cycle count and hang guard
    // ----------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test;
        end
    end
    task chk(input string nm, input logic [36:0] exp, input logic [36:0] got);
        begin
            n_checks++;
            if (got !== exp) begin
                n_mismatch++;
                $display("[ERR] %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // bounded wait on a level, counting cycles
    task wait_for(input bit fr);
        begin
            n = 0;
            while ((fr ? frame : busy) !== fr && n < 5000) begin
                @(negedge clk);
                n++;
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        rst = 1'b1;
        osc_pin = 1'b1;
        powerdown_select = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rel = cyc;
        @(negedge clk);
        chk("busy", 1, busy);
        chk("settings", DEF, st);
        chk("serial idle", 1, sidle);
        u_lcri_host_model.status_read(v, oe);
        chk("busy read", 37'h1ff, {oe, v[7]});
        for (n = 0; clearing === 1'b1 && n < 1000; n++) @(negedge clk);
        chk("clear ticks", 1, cyc - rel >= 165 && cyc - rel <= 168);
        wait_for(1'b0);
        chk("busy time", 1, cyc - rel >= BUSY - 2 && cyc - rel <= BUSY + 2);
        u_lcri_host_model.status_read(v, oe);
        u_lcri_host_model.status_read(v, oe);
        chk("idle read", 37'h1fe, {oe, v[7]});
        for (r = 0; r < 4; r++) begin
            @(posedge clk);
            osc_pin <= rows[r][5];
            powerdown_select <= rows[r][4];
            repeat (3) @(negedge clk);
            chk("clock mode", rows[r][3:0], {use_int, osc_run, tick, gnd});
            chk("state kept", DEF, st);
        end
        @(posedge clk);
        osc_pin <= 1'b1;
        powerdown_select <= 1'b0;
        u_lcri_host_model.write_cycle(8'h08);
        chk("addr select", {1'b1, 8'h00}, {d3, data_oe});
        u_lcri_host_model.write_cycle(8'h00);
        chk("addr select", 0, d3);
        u_lcri_host_model.idle();
        wait_for(1'b1);
        fork
            begin
                @(negedge clk);
                wait_for(1'b1);
            end
            repeat (4) u_lcri_host_model.status_read(v, oe);
        join
        chk("frame cycles", 3071, n);
        u_lcri_host_model.ext_pulse(2);
        repeat (3) @(negedge clk);
        chk("short pulse", 0, busy);
        u_lcri_host_model.ext_pulse(3);
        @(negedge clk);
        chk("long pulse", 1, busy);
        wait_for(1'b0);
        chk("settings", DEF, st);
        finish_test;
    end
endmodule // lcri_reset_init_tb
